// File: rtl/fdcg_defines.svh
`ifndef FDCG_DEFINES_SVH
`define FDCG_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define FDCG_OFS_CAL_PORT 8'h05
`define FDCG_OFS_VOLT 8'h06

// ----------------------------------------
// Field positions, calibration/port register
// ----------------------------------------
`define FDCG_BIT_CAL_START 7
`define FDCG_BIT_PSAVE 6
`define FDCG_BIT_DIR 5
`define FDCG_BIT_PORT_VAL 4
`define FDCG_BIT_DRIVE 3
`define FDCG_BIT_CH3 2
`define FDCG_BIT_CH2 1
`define FDCG_BIT_CH1 0

// ----------------------------------------
// Field positions, voltage register
// ----------------------------------------
`define FDCG_BIT_HDR 4
`define FDCG_VCODE_W 4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define FDCG_RST_PSAVE 1'h1
`define FDCG_RST_DIR 1'h1
`define FDCG_RST_PORT_VAL 1'h0
`define FDCG_RST_DRIVE 1'h1
`define FDCG_RST_CH 3'h2
`define FDCG_RST_VCODE 4'h9
`define FDCG_RST_HDR 1'h0

`endif

// File: rtl/fdcg_pkg.sv
package fdcg_pkg;
    // Calibration sequencer states
    typedef enum logic [2:0] {
        FDCG_CAL_IDLE = 3'h1,
        FDCG_CAL_RUN = 3'h2,
        FDCG_CAL_DONE = 3'h4
    } fdcg_cal_state_t;
endpackage : fdcg_pkg

// File: rtl/fdcg_regs.sv
`timescale 1ns/1ps
`include "fdcg_defines.svh"

// How it works
// - A one written to calibration bit 7 starts self-calibration, a zero disables it.
// - Reading bit 7 gives zero while calibration runs and one once it has finished.
// - The done indication is cleared only when a calibration cycle starts or restarts.
// - Bit 6 enables power-save mode and resets to one.
// - A read of bit 5 returns the live level of the DC-light enable pin.
// - A write of bit 5 sets port direction, one for output, and it resets to one.
// - Bit 4 holds the port value and resets to zero.
// - Bit 3 selects push-pull at zero or open-drain at one, resetting to open-drain.
// - Bits 2 to 0 enable LED channels three, two and one, resetting to 0, 1 and 0.
// - Bit 4 of the voltage register is read-only headroom status, one meaning enough.
// - Headroom is sampled once at the end of each flash strobe before ramp-down.
// - Reading the voltage code returns the current target code, from the latest host write or calibration.
// - Writing the voltage code sets the boost target, 3.825 V to 5.700 V, reset 1001.
// - The port pin carries power-good or the stored port value per the select bit.
module fdcg_regs (
    input wire logic core_clk_in, // 125 MHz clock
    input wire logic rst_in, // Sync reset, active high
    input wire logic ce_in, // Clock enable
    input wire logic [7:0] reg_addr_in, // Register address
    input wire logic reg_wr_in, // Write strobe
    input wire logic [7:0] reg_wdata_in, // Write data
    output logic [7:0] reg_rdata_out, // Read data, next cycle
    input wire logic dc_light_enable_input_in, // DC-light enable pin
    input wire logic power_good_select_in, // Power-good select bit
    input wire logic power_good_in, // Power-good status
    input wire logic strobe_end_in, // End-of-strobe pulse
    input wire logic headroom_sense_in, // Analog headroom comparator
    input wire logic cal_finish_in, // Calibration engine finished pulse
    input wire logic [3:0] cal_code_in, // Code found by calibration
    input wire logic port_pin_in, // Port pin level
    output logic port_pin_out, // Port pin drive value
    output logic port_pin_oe_out, // Port pin output enable
    output logic cal_run_out, // Calibration engine enable
    output logic power_save_enable_out, // Power-save enable
    output logic [2:0] channel_enable_out, // LED channels 3..1
    output logic [3:0] target_voltage_code_out // Boost target code
);
    // ----------------------------------------
    // Synchronised pin inputs
    // ----------------------------------------
    logic [4:0] sync_q;
    logic dcl_s;
    logic pg_s;
    logic hdr_s;
    logic pin_s;
    logic sel_s;

    fdcg_sync #(.WIDTH(5)) u_sync (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .d_in({dc_light_enable_input_in, power_good_in, headroom_sense_in,
               port_pin_in, power_good_select_in}),
        .q_out(sync_q)
    );
    assign {dcl_s, pg_s, hdr_s, pin_s, sel_s} = sync_q;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    logic wr_cal;
    logic wr_volt;
    assign wr_cal = reg_wr_in && (reg_addr_in == `FDCG_OFS_CAL_PORT);
    assign wr_volt = reg_wr_in && (reg_addr_in == `FDCG_OFS_VOLT);

    // ----------------------------------------
    // Calibration sequencer
    // ----------------------------------------
    fdcg_pkg::fdcg_cal_state_t cal_state_r;
    logic cal_done;
    logic cal_fin_ok;
    assign cal_done = (cal_state_r == fdcg_pkg::FDCG_CAL_DONE);
    // A finish counts unless a restart lands in the same cycle
    assign cal_fin_ok = (cal_state_r == fdcg_pkg::FDCG_CAL_RUN) && cal_finish_in
        && !(wr_cal && reg_wdata_in[`FDCG_BIT_CAL_START]);

    // Start, restart, disable and completion
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            cal_state_r <= fdcg_pkg::FDCG_CAL_IDLE;
        end else if (ce_in) begin
            if (wr_cal && reg_wdata_in[`FDCG_BIT_CAL_START]) begin
                cal_state_r <= fdcg_pkg::FDCG_CAL_RUN;
            end else begin
                unique case (cal_state_r)
                    fdcg_pkg::FDCG_CAL_IDLE: begin
                        cal_state_r <= fdcg_pkg::FDCG_CAL_IDLE;
                    end
                    fdcg_pkg::FDCG_CAL_RUN: begin
                        // Finish wins over a same-cycle abort
                        if (cal_finish_in) begin
                            cal_state_r <= fdcg_pkg::FDCG_CAL_DONE;
                        end else if (wr_cal) begin
                            cal_state_r <= fdcg_pkg::FDCG_CAL_IDLE;
                        end
                    end
                    fdcg_pkg::FDCG_CAL_DONE: begin
                        cal_state_r <= fdcg_pkg::FDCG_CAL_DONE;
                    end
                    default: begin
                        cal_state_r <= fdcg_pkg::FDCG_CAL_IDLE;
                    end
                endcase
            end
        end
    end

    // Engine enable
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            cal_run_out <= 1'h0;
        end else if (ce_in) begin
            if (wr_cal) begin
                cal_run_out <= reg_wdata_in[`FDCG_BIT_CAL_START];
            end else if (cal_state_r == fdcg_pkg::FDCG_CAL_RUN && cal_finish_in) begin
                cal_run_out <= 1'h0;
            end
        end
    end

    // ----------------------------------------
    // Control bits of the calibration/port register
    // ----------------------------------------
    logic dir_r;
    logic port_val_r;
    logic drive_r;

    // Plain writable fields
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            power_save_enable_out <= `FDCG_RST_PSAVE;
            dir_r <= `FDCG_RST_DIR;
            port_val_r <= `FDCG_RST_PORT_VAL;
            drive_r <= `FDCG_RST_DRIVE;
            channel_enable_out <= `FDCG_RST_CH;
        end else if (ce_in && wr_cal) begin
            power_save_enable_out <= reg_wdata_in[`FDCG_BIT_PSAVE];
            dir_r <= reg_wdata_in[`FDCG_BIT_DIR];
            port_val_r <= reg_wdata_in[`FDCG_BIT_PORT_VAL];
            drive_r <= reg_wdata_in[`FDCG_BIT_DRIVE];
            channel_enable_out <= reg_wdata_in[`FDCG_BIT_CH3:`FDCG_BIT_CH1];
        end
    end

    // ----------------------------------------
    // Port pin driver
    // ----------------------------------------
    logic port_src;
    assign port_src = sel_s ? port_val_r : pg_s;

    // Push-pull drives both levels, open-drain only pulls low
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            port_pin_out <= 1'h0;
            port_pin_oe_out <= 1'h0;
        end else if (ce_in) begin
            port_pin_out <= port_src;
            port_pin_oe_out <= dir_r && (!drive_r || !port_src);
        end
    end

    // ----------------------------------------
    // Voltage register
    // ----------------------------------------
    logic headroom_ok_r;

    // Headroom sampled at end of strobe only
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            headroom_ok_r <= `FDCG_RST_HDR;
        end else if (ce_in && strobe_end_in) begin
            headroom_ok_r <= hdr_s;
        end
    end

    // Target code: host write, then calibration result overrides
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            target_voltage_code_out <= `FDCG_RST_VCODE;
        end else if (ce_in) begin
            if (cal_fin_ok) begin
                target_voltage_code_out <= cal_code_in;
            end else if (wr_volt) begin
                target_voltage_code_out <= reg_wdata_in[`FDCG_VCODE_W-1:0];
            end
        end
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    logic [7:0] rd_nxt;

    // Read multiplexer
    always_comb begin
        rd_nxt = 8'h00;
        if (reg_addr_in == `FDCG_OFS_CAL_PORT) begin
            rd_nxt[`FDCG_BIT_CAL_START] = cal_done;
            rd_nxt[`FDCG_BIT_PSAVE] = power_save_enable_out;
            rd_nxt[`FDCG_BIT_DIR] = dcl_s;
            rd_nxt[`FDCG_BIT_PORT_VAL] = dir_r ? port_val_r : pin_s;
            rd_nxt[`FDCG_BIT_DRIVE] = drive_r;
            rd_nxt[`FDCG_BIT_CH3:`FDCG_BIT_CH1] = channel_enable_out;
        end else if (reg_addr_in == `FDCG_OFS_VOLT) begin
            rd_nxt[`FDCG_BIT_HDR] = headroom_ok_r;
            rd_nxt[`FDCG_VCODE_W-1:0] = target_voltage_code_out;
        end
    end

    // Registered read data
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            reg_rdata_out <= 8'h00;
        end else if (ce_in) begin
            reg_rdata_out <= rd_nxt;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    AST_CAL_START: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (ce_in && wr_cal && reg_wdata_in[7]) |=> (cal_run_out && !cal_done))
        else $error("calibration did not start");
    AST_CAL_DONE: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (ce_in && cal_fin_ok) |=> cal_done)
        else $error("calibration done not flagged");
    AST_DONE_HOLD: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (cal_done && !(ce_in && wr_cal && reg_wdata_in[7])) |=> cal_done)
        else $error("done cleared without restart");
    AST_PSAVE_WR: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (ce_in && wr_cal) |=> (power_save_enable_out == $past(reg_wdata_in[6])))
        else $error("power save not written");
    AST_RD_DCL: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (ce_in && reg_addr_in == 8'h05) |=> (reg_rdata_out[5] == $past(dcl_s)))
        else $error("bit 5 read wrong");
    AST_CH_WR: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (ce_in && wr_cal) |=> (channel_enable_out == $past(reg_wdata_in[2:0])))
        else $error("channel enables not written");
    AST_HDR_STABLE: assert property (@(posedge core_clk_in) disable iff (rst_in)
        !(ce_in && strobe_end_in) |=> $stable(headroom_ok_r))
        else $error("headroom changed outside strobe end");
    AST_HDR_RD: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (ce_in && reg_addr_in == 8'h06) |=> (reg_rdata_out[4] == $past(headroom_ok_r)))
        else $error("headroom read wrong");
    AST_VCODE_WR: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (ce_in && wr_volt && !(cal_state_r == fdcg_pkg::FDCG_CAL_RUN && cal_finish_in))
        |=> (target_voltage_code_out == $past(reg_wdata_in[3:0])))
        else $error("voltage code not written");
    AST_DIR_WR: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (ce_in && wr_cal) |=> (dir_r == $past(reg_wdata_in[`FDCG_BIT_DIR])))
        else $error("port direction not written");
    AST_IN_NO_DRIVE: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (ce_in && !dir_r) |=> !port_pin_oe_out)
        else $error("input port driven");
    AST_PORT_VAL_WR: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (ce_in && wr_cal) |=> (port_val_r == $past(reg_wdata_in[`FDCG_BIT_PORT_VAL])))
        else $error("port value not written");
    AST_RD_PIN_IN: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (ce_in && reg_addr_in == `FDCG_OFS_CAL_PORT && !dir_r)
        |=> (reg_rdata_out[`FDCG_BIT_PORT_VAL] == $past(pin_s)))
        else $error("input port level read wrong");
    AST_DRIVE_WR: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (ce_in && wr_cal) |=> (drive_r == $past(reg_wdata_in[`FDCG_BIT_DRIVE])))
        else $error("port drive type not written");
    AST_OD_HIGH: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (ce_in && drive_r && port_src) |=> !port_pin_oe_out)
        else $error("open-drain port driven high");
    AST_PIN_PORT: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (ce_in && sel_s) |=> (port_pin_out == $past(port_val_r)))
        else $error("port value not on pin");
    AST_PIN_PG: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (ce_in && !sel_s) |=> (port_pin_out == $past(pg_s)))
        else $error("power good not on pin");
    AST_HDR_SAMPLE: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (ce_in && strobe_end_in) |=> (headroom_ok_r == $past(hdr_s)))
        else $error("headroom not sampled at strobe end");
    AST_RD_CAL: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (ce_in && reg_addr_in == `FDCG_OFS_CAL_PORT)
        |=> (reg_rdata_out[`FDCG_BIT_CAL_START] == $past(cal_done)))
        else $error("calibration status read wrong");
    AST_CAL_CODE: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (ce_in && cal_fin_ok) |=> (target_voltage_code_out == $past(cal_code_in)))
        else $error("calibration code not taken");
    AST_RD_CODE: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (ce_in && reg_addr_in == `FDCG_OFS_VOLT)
        |=> (reg_rdata_out[`FDCG_VCODE_W-1:0] == $past(target_voltage_code_out)))
        else $error("voltage code read wrong");
    AST_CAL_ABORT: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (ce_in && wr_cal && !reg_wdata_in[`FDCG_BIT_CAL_START] && !cal_finish_in
        && cal_state_r == fdcg_pkg::FDCG_CAL_RUN) |=> (!cal_run_out && !cal_done))
        else $error("calibration not stopped");

    // ----------------------------------------
    // Cover properties
    // ----------------------------------------
    COV_CAL: cover property (@(posedge core_clk_in) disable iff (rst_in)
        cal_state_r == fdcg_pkg::FDCG_CAL_RUN ##[1:20] cal_done);
    COV_HDR: cover property (@(posedge core_clk_in) disable iff (rst_in)
        ce_in && strobe_end_in && hdr_s);
    COV_OD: cover property (@(posedge core_clk_in) disable iff (rst_in)
        dir_r && drive_r && port_pin_oe_out);
    COV_ABORT: cover property (@(posedge core_clk_in) disable iff (rst_in)
        cal_state_r == fdcg_pkg::FDCG_CAL_RUN ##1 cal_state_r == fdcg_pkg::FDCG_CAL_IDLE);
    COV_PORT_IN: cover property (@(posedge core_clk_in) disable iff (rst_in)
        ce_in && reg_addr_in == `FDCG_OFS_CAL_PORT && !dir_r);
endmodule : fdcg_regs

// File: rtl/fdcg_sync.sv
`timescale 1ns/1ps
`include "fdcg_defines.svh"

// Two-stage synchroniser for pin levels
module fdcg_sync #(
    parameter int WIDTH = 1
) (
    input wire logic core_clk_in, // Clock
    input wire logic rst_in, // Sync reset
    input wire logic ce_in, // Clock enable
    input wire logic [WIDTH-1:0] d_in, // Async levels
    output logic [WIDTH-1:0] q_out // Synchronised levels
);
    logic [WIDTH-1:0] meta_r;

    // Two flops per bit
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            meta_r <= '0;
            q_out <= '0;
        end else if (ce_in) begin
            meta_r <= d_in;
            q_out <= meta_r;
        end
    end
endmodule : fdcg_sync

// File: sim/fdcg_host.sv
`timescale 1ns/1ps

// Host side of the register bus
module fdcg_host (
    input wire logic core_clk_in, // Clock
    output logic [7:0] reg_addr_out, // Address
    output logic reg_wr_out, // Write strobe
    output logic [7:0] reg_wdata_out, // Write data
    input wire logic [7:0] reg_rdata_in // Read data
);
    // Idle bus at time zero
    initial begin
        reg_addr_out = 8'h00;
        reg_wr_out = 1'h0;
        reg_wdata_out = 8'h00;
    end

    // One-cycle write; write data is inverted once the strobe drops
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        #1;
        reg_addr_out = a;
        reg_wdata_out = d;
        reg_wr_out = 1'h1;
        @(posedge core_clk_in);
        #1;
        reg_wr_out = 1'h0;
        reg_wdata_out = ~d;
    endtask : wr

    // Read data is registered one cycle after the address
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk_in);
        #1;
        reg_addr_out = a;
        @(posedge core_clk_in);
        #1;
        d = reg_rdata_in;
    endtask : rd
endmodule : fdcg_host

// File: sim/fdcg_tb_top.sv
`timescale 1ns/1ps

// Register bank bench
module fdcg_tb_top;
    typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] r;} fdcg_row_t;
    logic clk, rst, ce, dc, pg_sel, pg, strobe, hdr, fin, pin, pin_out, pin_oe, run, psave;
    logic [3:0] code, vcode;
    logic [2:0] ch;
    logic [7:0] addr, wdata, rdata, v;
    logic wr;
    int mismatches = 0;
    int cmp_count = 0;
    fdcg_row_t rows [7] = '{'{8'h07, 8'hFF, 8'h00}, '{8'h05, 8'h3F, 8'h1F},
        '{8'h05, 8'h64, 8'h44}, '{8'h05, 8'h6A, 8'h4A}, '{8'h06, 8'hFF, 8'h0F},
        '{8'h06, 8'hE0, 8'h00}, '{8'h06, 8'h09, 8'h09}};

    fdcg_regs fdcg_regs_i (.core_clk_in(clk), .rst_in(rst), .ce_in(ce),
        .reg_addr_in(addr), .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
        .dc_light_enable_input_in(dc), .power_good_select_in(pg_sel), .power_good_in(pg),
        .strobe_end_in(strobe), .headroom_sense_in(hdr), .cal_finish_in(fin),
        .cal_code_in(code), .port_pin_in(pin), .port_pin_out(pin_out),
        .port_pin_oe_out(pin_oe), .cal_run_out(run), .power_save_enable_out(psave),
        .channel_enable_out(ch), .target_voltage_code_out(vcode));
    fdcg_host fdcg_host_i (.core_clk_in(clk), .reg_addr_out(addr), .reg_wr_out(wr),
        .reg_wdata_out(wdata), .reg_rdata_in(rdata));

    // Clock
    initial begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end

    // Compare one value
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Wait edges, then step off the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    // Read a register and compare
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        fdcg_host_i.rd(a, v);
        chk(v, exp);
    endtask : rchk

    // Reset and reset values
    task automatic do_reset(input int n, input logic [7:0] exp5);
        rst = 1'h1;
        tick(n);
        rst = 1'h0;
        tick(4);
        rchk(8'h05, exp5);
        rchk(8'h06, 8'h09);
        chk({4'h0, psave, ch}, 8'h0A);
        chk({3'h0, run, vcode}, 8'h09);
        $display("Test reset done");
    endtask : do_reset

    // Closing
    task automatic end_sim;
        $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_sim

    // Pulse a same-clock input for one cycle
    task automatic cal_done(input logic [3:0] c);
        fin = 1'h1;
        code = c;
        tick(1);
        fin = 1'h0;
    endtask : cal_done

    // Watchdog
    initial begin
        #100000;
        mismatches++;
        end_sim();
    end

    // Main sequence
    initial begin
        // Reset and enable high, pin source is the port value, all else low
        {rst, ce, dc, pg_sel, pg, strobe, hdr, fin, pin, code} = 13'h1A00;
        do_reset(12, 8'h4A);
        foreach (rows[i]) begin
            fdcg_host_i.wr(rows[i].a, rows[i].d);
            rchk(rows[i].a, rows[i].r);
            if (rows[i].a == 8'h05)
                chk({4'h0, psave, ch}, {4'h0, rows[i].d[6], rows[i].d[2:0]});
            if (rows[i].a == 8'h06)
                chk({4'h0, vcode}, {4'h0, rows[i].d[3:0]});
        end
        $display("Test table done");
        // Calibration start, done, read-back and restart
        fdcg_host_i.wr(8'h05, 8'hEA);
        chk({7'h0, run}, 8'h01);
        rchk(8'h05, 8'h4A);
        cal_done(4'h3);
        tick(1);
        chk({7'h0, run}, 8'h00);
        rchk(8'h05, 8'hCA);
        rchk(8'h06, 8'h03);
        rchk(8'h05, 8'hCA);
        fdcg_host_i.wr(8'h05, 8'h6A);
        rchk(8'h05, 8'hCA);
        fdcg_host_i.wr(8'h05, 8'hEA);
        rchk(8'h05, 8'h4A);
        fdcg_host_i.wr(8'h05, 8'h6A);
        chk({7'h0, run}, 8'h00);
        rchk(8'h05, 8'h4A);
        fdcg_host_i.wr(8'h05, 8'hEA);
        cal_done(4'h5);
        $display("Test calibration done");
        // Headroom updates only at strobe end
        hdr = 1'h1;
        tick(4);
        rchk(8'h06, 8'h05);
        strobe = 1'h1;
        tick(1);
        strobe = 1'h0;
        rchk(8'h06, 8'h15);
        fdcg_host_i.wr(8'h06, 8'h05);
        rchk(8'h06, 8'h15);
        hdr = 1'h0;
        tick(4);
        rchk(8'h06, 8'h15);
        $display("Test headroom done");
        // Port pin drive, input mode and pin source
        dc = 1'h1;
        tick(4);
        rchk(8'h05, 8'hEA);
        fdcg_host_i.wr(8'h05, 8'h30);
        tick(4);
        chk({6'h0, pin_oe, pin_out}, 8'h03);
        fdcg_host_i.wr(8'h05, 8'h38);
        tick(4);
        chk({7'h0, pin_oe}, 8'h00);
        fdcg_host_i.wr(8'h05, 8'h28);
        tick(4);
        chk({6'h0, pin_oe, pin_out}, 8'h02);
        pin = 1'h1;
        fdcg_host_i.wr(8'h05, 8'h00);
        tick(4);
        chk({7'h0, pin_oe}, 8'h00);
        rchk(8'h05, 8'hB0);
        pg_sel = 1'h0;
        fdcg_host_i.wr(8'h05, 8'h30);
        tick(4);
        chk({7'h0, pin_out}, 8'h00);
        pg = 1'h1;
        tick(4);
        chk({6'h0, pin_oe, pin_out}, 8'h03);
        $display("Test port done");
        do_reset(2, 8'h6A);
        end_sim();
    end
endmodule : fdcg_tb_top
